/* File: bench/mdp_fabric_model.sv */
/* Fabric-side model for the MAC slice: drives operands and per-half controls.
   Assumes the bench calls drive off the sampling edge of ref_clk. */
`timescale 1ns/1ps
module mdp_fabric_model (
    output logic clock_gate_on,
    output logic [15:0] a_in,
    output logic [15:0] b_in,
    output logic [15:0] c_in,
    output logic [15:0] d_in,
    output logic a_reg_freeze,
    output logic b_reg_freeze,
    output logic c_reg_freeze,
    output logic d_reg_freeze,
    output logic upper_input_clear,
    output logic lower_input_clear,
    output logic acc_hi_freeze,
    output logic acc_lo_freeze,
    output logic acc_hi_clear,
    output logic acc_lo_clear,
    output logic acc_hi_load_sel,
    output logic acc_lo_load_sel,
    output logic acc_hi_sub_sel,
    output logic acc_lo_sub_sel,
    output logic cascade_carry_from_prev,
    output logic tile_carry_in,
    output logic sign_extend_from_prev
);
    // ****************************************
    // Chain inputs held idle
    // ****************************************
    assign cascade_carry_from_prev = 1'b0;
    assign tile_carry_in = 1'b0;
    assign sign_extend_from_prev = 1'b0;

    // ****************************************
    // Operand and control driver
    // ****************************************
    task automatic drive(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                         input logic [15:0] d, input logic [13:0] k, input logic en);
        begin
            clock_gate_on <= en;
            {a_in, b_in, c_in, d_in} <= {a, b, c, d};
            {acc_lo_sub_sel, acc_hi_sub_sel, acc_lo_load_sel, acc_hi_load_sel, acc_lo_clear,
             acc_hi_clear, acc_lo_freeze, acc_hi_freeze, lower_input_clear, upper_input_clear,
             d_reg_freeze, c_reg_freeze, b_reg_freeze, a_reg_freeze} <= k;
        end
    endtask : drive

    initial begin
        drive(16'h0000, 16'h0000, 16'h0000, 16'h0000, 14'h0000, 1'b1);
    end
endmodule : mdp_fabric_model

/* File: bench/mdp_mac_datapath16_bench.sv */
/* Self-checking bench for the MAC slice: mode register over AXI4-Lite, datapath runs.
   Assumes the fabric model drives operands and controls. */
`timescale 1ns/1ps
module mdp_mac_datapath16_bench;
    logic ref_clk, reset_n, clock_gate_on, a_reg_freeze, b_reg_freeze, c_reg_freeze;
    logic d_reg_freeze, upper_input_clear, lower_input_clear, acc_hi_freeze, acc_lo_freeze;
    logic acc_hi_clear, acc_lo_clear, acc_hi_load_sel, acc_lo_load_sel, acc_hi_sub_sel;
    logic acc_lo_sub_sel, cascade_carry_from_prev, tile_carry_in, sign_extend_from_prev;
    logic cascade_carry_to_next, tile_carry_out, sign_extend_to_next;
    logic [15:0] a_in, b_in, c_in, d_in;
    logic [31:0] result_out, s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int err_count, checks, cyc;

    mdp_fabric_model i_mdp_fabric_model (.clock_gate_on(clock_gate_on), .a_in(a_in),
        .b_in(b_in), .c_in(c_in), .d_in(d_in), .a_reg_freeze(a_reg_freeze),
        .b_reg_freeze(b_reg_freeze), .c_reg_freeze(c_reg_freeze), .d_reg_freeze(d_reg_freeze),
        .upper_input_clear(upper_input_clear), .lower_input_clear(lower_input_clear),
        .acc_hi_freeze(acc_hi_freeze), .acc_lo_freeze(acc_lo_freeze),
        .acc_hi_clear(acc_hi_clear), .acc_lo_clear(acc_lo_clear),
        .acc_hi_load_sel(acc_hi_load_sel), .acc_lo_load_sel(acc_lo_load_sel),
        .acc_hi_sub_sel(acc_hi_sub_sel), .acc_lo_sub_sel(acc_lo_sub_sel),
        .cascade_carry_from_prev(cascade_carry_from_prev), .tile_carry_in(tile_carry_in),
        .sign_extend_from_prev(sign_extend_from_prev));

    mdp_mac_datapath16 i_mdp_mac_datapath16 (.ref_clk(ref_clk), .reset_n(reset_n),
        .clock_gate_on(clock_gate_on), .a_in(a_in), .b_in(b_in), .c_in(c_in), .d_in(d_in),
        .a_reg_freeze(a_reg_freeze), .b_reg_freeze(b_reg_freeze), .c_reg_freeze(c_reg_freeze),
        .d_reg_freeze(d_reg_freeze), .upper_input_clear(upper_input_clear),
        .lower_input_clear(lower_input_clear), .acc_hi_freeze(acc_hi_freeze),
        .acc_lo_freeze(acc_lo_freeze), .acc_hi_clear(acc_hi_clear), .acc_lo_clear(acc_lo_clear),
        .acc_hi_load_sel(acc_hi_load_sel), .acc_lo_load_sel(acc_lo_load_sel),
        .acc_hi_sub_sel(acc_hi_sub_sel), .acc_lo_sub_sel(acc_lo_sub_sel),
        .cascade_carry_from_prev(cascade_carry_from_prev), .tile_carry_in(tile_carry_in),
        .sign_extend_from_prev(sign_extend_from_prev), .result_out(result_out),
        .cascade_carry_to_next(cascade_carry_to_next), .tile_carry_out(tile_carry_out),
        .sign_extend_to_next(sign_extend_to_next), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            results();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic results;
        begin
            $display("checks %0d mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask : results

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        begin
            checks++;
            if (got !== ex) begin
                err_count++;
                $display("MISMATCH %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask : chk

    task automatic axi_write(input logic [3:0] ad, input logic [31:0] dt, input logic [1:0] rs);
        begin
            s_axi_awaddr <= ad;
            s_axi_wdata <= dt;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge ref_clk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            chk("bresp", 32'(rs), 32'(s_axi_bresp));
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] ad, input logic [31:0] ex, input logic [1:0] rs);
        begin
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge ref_clk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
            chk("rdata", ex, s_axi_rdata);
            chk("rresp", 32'(rs), 32'(s_axi_rresp));
        end
    endtask : axi_read

    // Clear both halves while the pipe fills, then run n cycles with controls k
    task automatic run(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                       input logic [13:0] k, input int n, input logic [31:0] ex);
        begin
            i_mdp_fabric_model.drive(a, b, c, 16'h0000, k | 14'h0300, 1'b1);
            repeat (4) @(posedge ref_clk);
            i_mdp_fabric_model.drive(a, b, c, 16'h0000, k, 1'b1);
            repeat (n) @(posedge ref_clk);
            #1;
            chk("result", ex, result_out);
        end
    endtask : run

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("reset result", 32'h0000_0000, result_out);
        axi_read(mdp_pkg::FLAGS_OFFSET, 32'h0000_0000, mdp_pkg::RESP_OKAY);
        axi_read(mdp_pkg::CFG_OFFSET, 32'(mdp_pkg::CFG_RESET), mdp_pkg::RESP_OKAY);
        axi_read(4'hC, 32'h0000_0000, mdp_pkg::RESP_SLVERR);
        axi_write(4'hC, 32'h0000_003F, mdp_pkg::RESP_SLVERR);
        run(16'h0003, 16'h0005, 16'h0000, 14'h0000, 2, 32'h0000_001E);
        run(16'hFFFF, 16'h0001, 16'h0000, 14'h0000, 2, 32'h0001_FFFE);
        run(16'h0101, 16'h0300, 16'h0000, 14'h0080, 2, 32'h0006_0000);
        run(16'h0101, 16'h0300, 16'h0000, 14'h0040, 2, 32'h0000_0600);
        run(16'h0101, 16'h0300, 16'h0000, 14'h0100, 2, 32'h0000_0600);
        run(16'h0003, 16'h0005, 16'h0000, 14'h3000, 1, 32'hFFFF_FFF1);
        chk("carry out", 32'h0000_0003, 32'({cascade_carry_to_next, tile_carry_out}));
        run(16'h0000, 16'h0000, 16'h1234, 14'h0C00, 1, 32'h1234_1234);
        run(16'h0003, 16'h0005, 16'h0000, 14'h0010, 2, 32'h0000_0000);
        run(16'h0003, 16'h0005, 16'h0000, 14'h0001, 2, 32'h0000_0000);
        run(16'h0003, 16'h0005, 16'h0000, 14'h0020, 2, 32'h0000_0000);
        axi_write(mdp_pkg::CFG_OFFSET, 32'h0000_0005, mdp_pkg::RESP_OKAY);
        run(16'h01FF, 16'h02FF, 16'h0000, 14'h0000, 2, 32'h0004_FC02);
        axi_write(mdp_pkg::CFG_OFFSET, 32'h0000_0000, mdp_pkg::RESP_OKAY);
        run(16'h0012, 16'h0034, 16'h0000, 14'h0000, 1, 32'h0012_0034);
        i_mdp_fabric_model.drive(16'h0012, 16'h0034, 16'h0000, 16'h0000, 14'h0000, 1'b0);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("gated result", 32'h0012_0034, result_out);
        i_mdp_fabric_model.drive(16'h0012, 16'h0034, 16'h0000, 16'h0000, 14'h00C0, 1'b1);
        axi_read(mdp_pkg::RESULT_OFFSET, 32'h0012_0034, mdp_pkg::RESP_OKAY);
        results();
    end
endmodule : mdp_mac_datapath16_bench

/* File: src/mdp_acc_half.sv */
/*
 * One 16-bit accumulator half: adder/subtracter plus result register.
 * Assumes the caller supplies the gated enable and the carry chain.
 */
`timescale 1ns/1ps
module mdp_acc_half #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic freeze,
    input wire logic load_sel,
    input wire logic sub_sel,
    input wire logic [W-1:0] load_val,
    input wire logic [W-1:0] base,
    input wire logic [W-1:0] opnd,
    input wire logic cin,
    output logic [W-1:0] acc_r,
    output logic cout_nxt
);
    logic [W:0] sum_nxt;

    // RULE_11: add or subtract
    always_comb begin
        if (sub_sel) begin
            sum_nxt = {1'b0, base} - {1'b0, opnd} - {{W{1'b0}}, cin};
        end else begin
            sum_nxt = {1'b0, base} + {1'b0, opnd} + {{W{1'b0}}, cin};
        end
        cout_nxt = sum_nxt[W];
    end

    // RULE_02: gated by enable
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= mdp_pkg::ACC_RESET[W-1:0];
        end else if (ce) begin
            // RULE_09: half clear first
            if (clear) begin
                acc_r <= mdp_pkg::ACC_RESET[W-1:0];
            // RULE_08: half hold
            end else if (!freeze) begin
                // RULE_10: load or accumulate
                acc_r <= load_sel ? load_val : sum_nxt[W-1:0];
            end
        end
    end
endmodule : mdp_acc_half

/* File: src/mdp_mac_datapath16.sv */
/*
 * Multiply-accumulate slice: four operand registers, split 16x16 multiplier,
 * two accumulator halves, carry and sign chains, AXI4-Lite mode register.
 * Assumes operands and controls come from fabric logic on ref_clk.
 */
//
// Overview of operation
// RULE_01: All slice registers run from the single clock ref_clk.
// RULE_02: One clock enable gates every register; low holds all contents. cfg_r and the AXI4-Lite handshake registers are not gated.
// RULE_03: Four 16-bit operand registers; A and B multiply, C and D add.
// RULE_04: Each operand register has its own hold control.
// RULE_05: Upper clear zeroes A, C and the upper product register.
// RULE_06: Lower clear zeroes B, D, lower and full product registers.
// RULE_07: Output is one 32-bit result or two independent 16-bit halves.
// RULE_08: Each accumulator half has its own hold input.
// RULE_09: Each accumulator half has its own clear input.
// RULE_10: Each half loads adder result, or C register when load selected.
// RULE_11: Each half adds when its select is low, subtracts when high.
// RULE_12: Carry in and out on both cascade and tile chains.
// RULE_13: Sign extension received from previous slice and sent to next.
// RULE_14: Supports 8x8, 16x16 multiply, 16/32-bit add, accumulate and MAC.
// RULE_15: Idle inputs at zero mean load, no clear, accumulate, add.
// RULE_16: Clock enable is active high; tie high when unused.
// RULE_17: Lower carry feeds upper half in 32-bit mode, not in dual mode.
//
`timescale 1ns/1ps
module mdp_mac_datapath16 (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clock_gate_on,
    input wire logic [15:0] a_in,
    input wire logic [15:0] b_in,
    input wire logic [15:0] c_in,
    input wire logic [15:0] d_in,
    input wire logic a_reg_freeze,
    input wire logic b_reg_freeze,
    input wire logic c_reg_freeze,
    input wire logic d_reg_freeze,
    input wire logic upper_input_clear,
    input wire logic lower_input_clear,
    input wire logic acc_hi_freeze,
    input wire logic acc_lo_freeze,
    input wire logic acc_hi_clear,
    input wire logic acc_lo_clear,
    input wire logic acc_hi_load_sel,
    input wire logic acc_lo_load_sel,
    input wire logic acc_hi_sub_sel,
    input wire logic acc_lo_sub_sel,
    input wire logic cascade_carry_from_prev,
    input wire logic tile_carry_in,
    input wire logic sign_extend_from_prev,
    output logic [31:0] result_out,
    output logic cascade_carry_to_next,
    output logic tile_carry_out,
    output logic sign_extend_to_next,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Declarations
    // ****************************************
    logic ce;
    logic [15:0] a_r, b_r, c_r, d_r;
    logic [15:0] prod_hi_r, prod_lo_r;
    logic [31:0] prod_full_r;
    logic [mdp_pkg::CFG_W-1:0] cfg_r;
    logic [31:0] prod_sel, opnd_sel;
    logic [15:0] base_hi, base_lo, acc_hi, acc_lo;
    logic lo_cin, hi_cin, lo_cout, hi_cout;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_commit, wr_hit;
    logic [31:0] rd_data;
    logic rd_hit;

    function automatic logic [15:0] mul8(input logic [7:0] x, input logic [7:0] y, input logic s);
        mul8 = {{8{s & x[7]}}, x} * {{8{s & y[7]}}, y};
    endfunction : mul8

    function automatic logic [31:0] mul16(input logic [15:0] x, input logic [15:0] y,
                                          input logic s);
        mul16 = {{16{s & x[15]}}, x} * {{16{s & y[15]}}, y};
    endfunction : mul16

    // RULE_16: active-high enable
    assign ce = clock_gate_on;

    // ****************************************
    // Operand registers
    // ****************************************
    // RULE_01: single clock domain
    // RULE_05: upper clear of A and C
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            a_r <= mdp_pkg::OPND_RESET;
            c_r <= mdp_pkg::OPND_RESET;
        end else if (ce && upper_input_clear) begin
            a_r <= mdp_pkg::OPND_RESET;
            c_r <= mdp_pkg::OPND_RESET;
        end else if (ce) begin
            // RULE_04: A and C hold
            if (!a_reg_freeze) begin
                a_r <= a_in;
            end
            if (!c_reg_freeze) begin
                c_r <= c_in;
            end
        end
    end

    // RULE_06: lower clear of B and D
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            b_r <= mdp_pkg::OPND_RESET;
            d_r <= mdp_pkg::OPND_RESET;
        end else if (ce && lower_input_clear) begin
            b_r <= mdp_pkg::OPND_RESET;
            d_r <= mdp_pkg::OPND_RESET;
        end else if (ce) begin
            // RULE_04: B and D hold
            if (!b_reg_freeze) begin
                b_r <= b_in;
            end
            if (!d_reg_freeze) begin
                d_r <= d_in;
            end
        end
    end

    // ****************************************
    // Multiplier pipeline
    // ****************************************
    // RULE_05: upper product clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prod_hi_r <= 16'h0000;
        end else if (ce) begin
            prod_hi_r <= upper_input_clear ? 16'h0000 :
                         mul8(a_r[15:8], b_r[15:8], cfg_r[mdp_pkg::CFG_SIGNED_BIT]);
        end
    end

    // RULE_06: lower and full product clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prod_lo_r <= 16'h0000;
            prod_full_r <= 32'h0000_0000;
        end else if (ce) begin
            if (lower_input_clear) begin
                prod_lo_r <= 16'h0000;
                prod_full_r <= 32'h0000_0000;
            end else begin
                // RULE_14: 8x8 and 16x16 products
                prod_lo_r <= mul8(a_r[7:0], b_r[7:0], cfg_r[mdp_pkg::CFG_SIGNED_BIT]);
                prod_full_r <= mul16(a_r, b_r, cfg_r[mdp_pkg::CFG_SIGNED_BIT]);
            end
        end
    end

    // ****************************************
    // Adder operand selection
    // ****************************************
    always_comb begin
        // RULE_07: dual halves or full product
        prod_sel = cfg_r[mdp_pkg::CFG_DUAL_BIT] ? {prod_hi_r, prod_lo_r} : prod_full_r;
        // RULE_13: sign extension from previous slice
        if (cfg_r[mdp_pkg::CFG_SEXT_BIT]) begin
            opnd_sel = {32{sign_extend_from_prev}};
        // RULE_03: A and B bypass the multiplier when CFG_MULT_BIT is low
        end else if (cfg_r[mdp_pkg::CFG_MULT_BIT]) begin
            opnd_sel = prod_sel;
        end else begin
            opnd_sel = {a_r, b_r};
        end
        // RULE_14: plain add of C:D or accumulate
        base_hi = cfg_r[mdp_pkg::CFG_ADDCD_BIT] ? c_r : acc_hi;
        base_lo = cfg_r[mdp_pkg::CFG_ADDCD_BIT] ? d_r : acc_lo;
        // RULE_12: carry from cascade or tile
        lo_cin = cfg_r[mdp_pkg::CFG_CASC_BIT] ? cascade_carry_from_prev : tile_carry_in;
        // RULE_17: chain halves unless dual
        hi_cin = cfg_r[mdp_pkg::CFG_DUAL_BIT] ? 1'b0 : lo_cout;
    end

    // ****************************************
    // Accumulator halves
    // ****************************************
    // RULE_15: zero controls accumulate and add
    mdp_acc_half #(.W(16)) u_acc_hi (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .clear(acc_hi_clear),
        .freeze(acc_hi_freeze), .load_sel(acc_hi_load_sel), .sub_sel(acc_hi_sub_sel),
        .load_val(c_r), .base(base_hi), .opnd(opnd_sel[31:16]), .cin(hi_cin),
        .acc_r(acc_hi), .cout_nxt(hi_cout)
    );

    mdp_acc_half #(.W(16)) u_acc_lo (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .clear(acc_lo_clear),
        .freeze(acc_lo_freeze), .load_sel(acc_lo_load_sel), .sub_sel(acc_lo_sub_sel),
        .load_val(c_r), .base(base_lo), .opnd(opnd_sel[15:0]), .cin(lo_cin),
        .acc_r(acc_lo), .cout_nxt(lo_cout)
    );

    // RULE_07: result packing
    assign result_out = {acc_hi, acc_lo};

    // ****************************************
    // Carry and sign outputs
    // ****************************************
    // RULE_12: carry to next slice and tile
    // RULE_13: sign to next slice
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cascade_carry_to_next <= 1'b0;
            tile_carry_out <= 1'b0;
            sign_extend_to_next <= 1'b0;
        end else if (ce) begin
            sign_extend_to_next <= cfg_r[mdp_pkg::CFG_SIGNED_BIT] & opnd_sel[31];
            if (acc_hi_clear) begin
                cascade_carry_to_next <= 1'b0;
                tile_carry_out <= 1'b0;
            end else if (!acc_hi_freeze) begin
                cascade_carry_to_next <= hi_cout;
                tile_carry_out <= hi_cout;
            end
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    assign wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = (aw_addr_r == mdp_pkg::CFG_OFFSET);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mdp_pkg::RESP_OKAY;
        end else if (wr_commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_hit || aw_addr_r == mdp_pkg::RESULT_OFFSET ||
                            aw_addr_r == mdp_pkg::FLAGS_OFFSET) ?
                           mdp_pkg::RESP_OKAY : mdp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= mdp_pkg::CFG_RESET;
        end else if (wr_commit && wr_hit && w_strb_r[0]) begin
            cfg_r <= w_data_r[mdp_pkg::CFG_W-1:0];
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            mdp_pkg::CFG_OFFSET: rd_data = {26'h000_0000, cfg_r};
            mdp_pkg::RESULT_OFFSET: rd_data = result_out;
            mdp_pkg::FLAGS_OFFSET: rd_data = {29'h0000_0000, sign_extend_to_next,
                                               cascade_carry_to_next, tile_carry_out};
            default: begin
                rd_data = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mdp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? mdp_pkg::RESP_OKAY : mdp_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_enable_low_hold: assert property (!ce [*2] // RULE_02
        |=> $stable(result_out) && $stable(a_r))
        else $error("Registers changed while enable low");
    a_a_reg_hold: assert property (ce && !upper_input_clear && a_reg_freeze // RULE_04
        |=> $stable(a_r))
        else $error("A register changed under hold");
    a_d_reg_load: assert property (ce && !lower_input_clear && !d_reg_freeze // RULE_04
        |=> d_r == $past(d_in))
        else $error("D register missed its load");
    a_upper_clear: assert property (ce && upper_input_clear // RULE_05
        |=> a_r == 16'h0000 && c_r == 16'h0000 && prod_hi_r == 16'h0000)
        else $error("Upper clear left data");
    a_lower_clear: assert property (ce && lower_input_clear // RULE_06
        |=> b_r == 16'h0000 && d_r == 16'h0000 && prod_lo_r == 16'h0000 && prod_full_r == 0)
        else $error("Lower clear left data");
    a_acc_hi_clear: assert property (ce && acc_hi_clear // RULE_09
        |=> result_out[31:16] == 16'h0000)
        else $error("Upper accumulator not cleared");
    a_acc_lo_hold: assert property (ce && !acc_lo_clear && acc_lo_freeze // RULE_08
        |=> $stable(result_out[15:0]))
        else $error("Lower accumulator changed under hold");
    a_acc_lo_load: assert property (ce && !acc_lo_clear && !acc_lo_freeze // RULE_10
        && acc_lo_load_sel |=> result_out[15:0] == $past(c_r))
        else $error("Lower accumulator did not load C");
    a_lo_accumulate: assert property (ce && !acc_lo_clear && !acc_lo_freeze // RULE_11
        && !acc_lo_load_sel && !acc_lo_sub_sel && !cfg_r[mdp_pkg::CFG_ADDCD_BIT]
        |=> result_out[15:0] == 16'($past(acc_lo) + $past(opnd_sel[15:0]) + 16'($past(lo_cin))))
        else $error("Lower accumulate sum wrong");
    a_dual_product: assert property (ce && !lower_input_clear // RULE_14
        && !cfg_r[mdp_pkg::CFG_SIGNED_BIT] |=> prod_lo_r ==
        {8'h00, $past(a_r[7:0])} * {8'h00, $past(b_r[7:0])})
        else $error("Lower 8x8 product wrong");
    a_dual_no_carry: assert property (cfg_r[mdp_pkg::CFG_DUAL_BIT] |-> hi_cin == 1'b0) // RULE_17
        else $error("Carry crossed halves in dual mode");
    a_carry_out: assert property (ce && !acc_hi_clear && !acc_hi_freeze // RULE_12
        |=> tile_carry_out == $past(hi_cout) && cascade_carry_to_next == tile_carry_out)
        else $error("Carry out not registered");
endmodule : mdp_mac_datapath16

/* File: src/mdp_pkg.sv */
/*
 * Shared constants for the 16-bit multiply-accumulate slice.
 * Assumes a single clock domain and an AXI4-Lite register port.
 */
package mdp_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int DATA_W = 16;
    localparam int AXI_ADDR_W = 4;
    localparam int CFG_W = 6;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [AXI_ADDR_W-1:0] CFG_OFFSET = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] RESULT_OFFSET = 4'h4;
    localparam logic [AXI_ADDR_W-1:0] FLAGS_OFFSET = 4'h8;

    // ****************************************
    // Configuration fields
    // ****************************************
    localparam int CFG_DUAL_BIT = 0;
    localparam int CFG_SIGNED_BIT = 1;
    localparam int CFG_MULT_BIT = 2;
    localparam int CFG_ADDCD_BIT = 3;
    localparam int CFG_CASC_BIT = 4;
    localparam int CFG_SEXT_BIT = 5;

    // ****************************************
    // Reset values and responses
    // ****************************************
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h04;
    localparam logic [DATA_W-1:0] OPND_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mdp_pkg
